// *** hdl/acl_cfg.svh ***
// constants for the acquisition control and line status block
`ifndef ACL_CFG_SVH
`define ACL_CFG_SVH
// register byte offsets
`define ACL_OFS_CTRL 5'h00
`define ACL_OFS_CMD 5'h04
`define ACL_OFS_LINE_SEL 5'h08
`define ACL_OFS_LINE_STAT 5'h0C
`define ACL_OFS_LINE_ALL 5'h10
`define ACL_OFS_STATUS 5'h14
// control register fields
`define ACL_CTRL_MODE_BIT 0
`define ACL_CTRL_SCHEME_BIT 1
// command register fields
`define ACL_CMD_START_BIT 0
`define ACL_CMD_STOP_BIT 1
// status register fields
`define ACL_STAT_ARMED_BIT 0
`define ACL_STAT_FRAME_BIT 1
`define ACL_STAT_GATE_BIT 2
`define ACL_STAT_STOPPEND_BIT 3
// line selector codes: 0..1 input lines, 2..5 output lines
`define ACL_SEL_W 3
`define ACL_SEL_FIRST_OUT 3'h2
`define ACL_SEL_LAST 3'h5
// all-lines word layout
`define ACL_ALL_IN_LSB 0
`define ACL_ALL_OUT_LSB 16
// reset values
`define ACL_RST_MODE 1'h0
`define ACL_RST_SCHEME 1'h0
`define ACL_RST_SEL 3'h2
`endif

// *** hdl/acl_pkg.sv ***
// types for the acquisition control and line status block
package acl_pkg;
  // one-hot acquisition states
  typedef enum logic [2:0]
  {
    ACL_ST_IDLE = 3'b001,
    ACL_ST_ARMED = 3'b010,
    ACL_ST_FRAME = 3'b100
  } acl_state_e;
  // acquisition mode and control scheme encodings
  typedef enum logic {ACL_SINGLE = 1'b0, ACL_CONTINUOUS = 1'b1} acl_mode_e;
  typedef enum logic {ACL_LEGACY = 1'b0, ACL_STANDARD = 1'b1} acl_scheme_e;
  // trigger and frame progress events, one-cycle pulses
  typedef struct packed
  {
    logic acq_start;
    logic frame_start;
    logic frame_done;
  } acl_trig_s;
  // present levels of the physical lines
  typedef struct packed
  {
    logic [3:0] out_lvl;
    logic [1:0] in_lvl;
  } acl_lines_s;
  // startup parameter set contents
  typedef struct packed
  {
    logic valid;
    acl_scheme_e scheme;
  } acl_startup_s;
endpackage

// *** hdl/acl_top.sv ***
// acquisition start/stop gating and i/o line status readback
`timescale 1ns/1ns
`default_nettype none
`include "acl_cfg.svh"
//==============================================================================
// What this block does
// R1: selected line status reads 1 when that line is high, 0 when low
// R2: a 32-bit word reports every input and output line level at once
// R3: each line bit of that word is 1 for high, 0 for low
// R4: inputs 1-2 at bits 0-1, outputs 1-4 at bits 16-19, rest zero
// R5: legacy and standard schemes; legacy lacks only the acquisition-enabling trigger
// R6: in legacy the frame start trigger acts as the acquisition start trigger
// R7: after power-up with no saved startup set the scheme is legacy
// R8: the scheme held in the startup set is restored at every reset
// R9: no frame is acquired before a start command; early triggers are dropped
// R10: single frame mode allows exactly one frame per start command
// R11: in single frame mode the armed state clears when that frame completes
// R12: continuous mode stays armed after each frame, without limit
// R13: continuous mode is disarmed only by a stop command
// R14: after a stop takes effect no frame is acquired until a new start
// R15: stop during a frame disarms after the frame; stop while idle disarms at once
module acl_top
#(
  parameter int ADDR_W = 5
)
(
  // clock and reset
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  // register port
  input wire logic [ADDR_W-1:0] ADDR_I,
  input wire logic [31:0] WR_DATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RD_DATA_O,
  // triggers, frame progress, line levels and startup set
  input wire acl_pkg::acl_trig_s TRIG_I,
  input wire acl_pkg::acl_lines_s LINES_I,
  input wire acl_pkg::acl_startup_s STARTUP_I,
  // acquisition outputs
  output logic FRAME_GO_O,
  output logic ARMED_O,
  output logic IN_FRAME_O
);
  import acl_pkg::*;

  // the decoder compares against 5-bit offsets; a narrower bus cannot reach them all
  if (ADDR_W < 5)
  begin : g_addr_w_check
    $error("acl_top: ADDR_W must be at least 5");
  end

  //============================================================================
  // helpers
  //============================================================================
  // address match used by every decode term
  function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [4:0] ofs);
    addr_hit = (a == ADDR_W'(ofs));
  endfunction

  //============================================================================
  // register decode
  //============================================================================
  wire logic wr_ctrl;
  wire logic wr_cmd;
  wire logic wr_sel;
  wire logic cmd_start;
  wire logic cmd_stop;
  assign wr_ctrl = WR_I && addr_hit(ADDR_I, `ACL_OFS_CTRL);
  assign wr_cmd = WR_I && addr_hit(ADDR_I, `ACL_OFS_CMD);
  assign wr_sel = WR_I && addr_hit(ADDR_I, `ACL_OFS_LINE_SEL);
  // commands are self-clearing: nothing is stored, the write is the event
  assign cmd_start = wr_cmd && WR_DATA_I[`ACL_CMD_START_BIT];
  assign cmd_stop = wr_cmd && WR_DATA_I[`ACL_CMD_STOP_BIT];

  //============================================================================
  // configuration registers
  //============================================================================
  acl_mode_e mode_r;
  acl_scheme_e scheme_r;
  logic [`ACL_SEL_W-1:0] sel_r;
  logic boot_r;
  acl_scheme_e scheme_nxt;

  // startup set is sampled on the first edge after reset release, not under reset
  always_comb
  begin
    scheme_nxt = scheme_r;
    if (boot_r)
      scheme_nxt = STARTUP_I.valid ? STARTUP_I.scheme : ACL_LEGACY; // R7 R8
    else if (wr_ctrl)
      scheme_nxt = acl_scheme_e'(WR_DATA_I[`ACL_CTRL_SCHEME_BIT]);
  end

  // mode, scheme and selector storage
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      mode_r <= acl_mode_e'(`ACL_RST_MODE);
      scheme_r <= acl_scheme_e'(`ACL_RST_SCHEME); // R7
      sel_r <= `ACL_RST_SEL;
      boot_r <= 1'b1;
    end
    else
    begin
      boot_r <= 1'b0;
      scheme_r <= scheme_nxt;
      if (wr_ctrl)
        mode_r <= acl_mode_e'(WR_DATA_I[`ACL_CTRL_MODE_BIT]);
      // out-of-range selector values are refused, the old one stays
      if (wr_sel && WR_DATA_I[`ACL_SEL_W-1:0] <= `ACL_SEL_LAST)
        sel_r <= WR_DATA_I[`ACL_SEL_W-1:0];
    end
  end

  //============================================================================
  // line status
  //============================================================================
  wire logic [5:0] line_vec;
  wire logic sel_lvl;
  wire logic [31:0] all_word;
  // selector order: inputs first, then outputs
  assign line_vec = {LINES_I.out_lvl, LINES_I.in_lvl};
  assign sel_lvl = line_vec[sel_r]; // R1
  // fixed layout, every unassigned bit is zero
  assign all_word = (32'(LINES_I.in_lvl) << `ACL_ALL_IN_LSB)
                  | (32'(LINES_I.out_lvl) << `ACL_ALL_OUT_LSB); // R2 R3 R4

  //============================================================================
  // acquisition control
  //============================================================================
  acl_state_e state_r;
  acl_state_e state_nxt;
  logic gate_r;
  logic gate_nxt;
  logic stop_pend_r;
  logic stop_pend_nxt;
  logic go_nxt;
  wire logic gate_open;
  wire logic frame_ok;

  // legacy has no acquisition-enabling trigger, so the gate is always open
  assign gate_open = (scheme_r == ACL_LEGACY) || gate_r; // R5
  // in legacy the same frame start input carries the acquisition start trigger
  assign frame_ok = TRIG_I.frame_start && gate_open; // R6

  // acquisition state machine
  always_comb
  begin
    state_nxt = state_r;
    gate_nxt = gate_r;
    stop_pend_nxt = stop_pend_r;
    go_nxt = 1'b0;
    case (state_r)
      ACL_ST_IDLE:
      begin
        gate_nxt = 1'b0;
        stop_pend_nxt = 1'b0;
        // triggers here are dropped: nothing has been armed
        if (cmd_start) // R9 R14
          state_nxt = ACL_ST_ARMED;
      end
      ACL_ST_ARMED:
      begin
        if (TRIG_I.acq_start && scheme_r == ACL_STANDARD)
          gate_nxt = 1'b1; // R5
        if (cmd_stop) // R13 R15
        begin
          state_nxt = ACL_ST_IDLE;
          gate_nxt = 1'b0;
        end
        else if (frame_ok)
        begin
          state_nxt = ACL_ST_FRAME;
          go_nxt = 1'b1;
        end
      end
      ACL_ST_FRAME:
      begin
        // a stop mid-frame waits for the frame to finish
        if (cmd_stop)
          stop_pend_nxt = 1'b1; // R15
        else if (cmd_start)
          stop_pend_nxt = 1'b0;
        if (TRIG_I.frame_done)
        begin
          if (mode_r == ACL_SINGLE || cmd_stop || stop_pend_r) // R10 R11 R15
          begin
            state_nxt = ACL_ST_IDLE;
            gate_nxt = 1'b0;
          end
          else
            state_nxt = ACL_ST_ARMED; // R12
          stop_pend_nxt = 1'b0;
        end
      end
      default:
      begin
        state_nxt = ACL_ST_IDLE;
        gate_nxt = 1'b0;
        stop_pend_nxt = 1'b0;
      end
    endcase
  end

  // state and output flops; ARMED_O and IN_FRAME_O mirror the state directly, FRAME_GO_O is the registered go pulse
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
    begin
      state_r <= ACL_ST_IDLE;
      gate_r <= 1'b0;
      stop_pend_r <= 1'b0;
      FRAME_GO_O <= 1'b0;
      ARMED_O <= 1'b0;
      IN_FRAME_O <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      gate_r <= gate_nxt;
      stop_pend_r <= stop_pend_nxt;
      FRAME_GO_O <= go_nxt;
      ARMED_O <= (state_nxt != ACL_ST_IDLE);
      IN_FRAME_O <= (state_nxt == ACL_ST_FRAME);
    end
  end

  //============================================================================
  // read path
  //============================================================================
  wire logic [31:0] status_word;
  wire logic [31:0] ctrl_word;
  logic [31:0] rd_nxt;
  assign ctrl_word = (32'(mode_r) << `ACL_CTRL_MODE_BIT) | (32'(scheme_r) << `ACL_CTRL_SCHEME_BIT);
  assign status_word = (32'(state_r != ACL_ST_IDLE) << `ACL_STAT_ARMED_BIT)
                     | (32'(state_r == ACL_ST_FRAME) << `ACL_STAT_FRAME_BIT)
                     | (32'(gate_open) << `ACL_STAT_GATE_BIT)
                     | (32'(stop_pend_r) << `ACL_STAT_STOPPEND_BIT);

  // read mux; unmapped and command offsets read zero
  always_comb
  begin
    rd_nxt = 32'h0000_0000;
    if (RD_I)
    begin
      if (addr_hit(ADDR_I, `ACL_OFS_CTRL))
        rd_nxt = ctrl_word;
      else if (addr_hit(ADDR_I, `ACL_OFS_LINE_SEL))
        rd_nxt = 32'(sel_r);
      else if (addr_hit(ADDR_I, `ACL_OFS_LINE_STAT))
        rd_nxt = 32'(sel_lvl); // R1
      else if (addr_hit(ADDR_I, `ACL_OFS_LINE_ALL))
        rd_nxt = all_word; // R2
      else if (addr_hit(ADDR_I, `ACL_OFS_STATUS))
        rd_nxt = status_word;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK_I)
  begin
    if (RST_I)
      RD_DATA_O <= 32'h0000_0000;
    else
      RD_DATA_O <= rd_nxt;
  end

  //============================================================================
  // checks
  //============================================================================
  default clocking cb @(posedge CORE_CLK_I);
  endclocking
  default disable iff (RST_I);

  sequence s_single_frame_end;
    state_r == ACL_ST_FRAME && mode_r == ACL_SINGLE && TRIG_I.frame_done;
  endsequence

  sequence s_disarmed;
    ##1 state_r == ACL_ST_IDLE ##0 !ARMED_O;
  endsequence

  a_line_stat_read: assert property (RD_I && addr_hit(ADDR_I, `ACL_OFS_LINE_STAT) // R1
    |=> RD_DATA_O == 32'($past(line_vec[sel_r])))
    else $error("line status read does not match selected line");
  a_all_word_map: assert property (RD_I && addr_hit(ADDR_I, `ACL_OFS_LINE_ALL) // R2 R3 R4
    |=> RD_DATA_O[1:0] == $past(LINES_I.in_lvl) && RD_DATA_O[19:16] == $past(LINES_I.out_lvl)
        && RD_DATA_O[15:2] == 14'h0000 && RD_DATA_O[31:20] == 12'h000)
    else $error("all-lines word layout wrong");
  a_no_frame_idle: assert property (state_r == ACL_ST_IDLE |=> !FRAME_GO_O) // R9 R14
    else $error("frame started while disarmed");
  a_legacy_gate_open: assert property (state_r == ACL_ST_ARMED && scheme_r == ACL_LEGACY // R5 R6
    && TRIG_I.frame_start && !cmd_stop |=> FRAME_GO_O && IN_FRAME_O)
    else $error("legacy frame trigger not taken");
  a_std_gate_closed: assert property (state_r == ACL_ST_ARMED && scheme_r == ACL_STANDARD // R5
    && !gate_r |=> !FRAME_GO_O)
    else $error("standard frame taken without acquisition start trigger");
  a_single_expire: assert property (s_single_frame_end |-> s_disarmed) // R10 R11
    else $error("single frame did not disarm");
  a_cont_stays: assert property (state_r == ACL_ST_FRAME && mode_r == ACL_CONTINUOUS // R12
    && TRIG_I.frame_done && !cmd_stop && !stop_pend_r |=> state_r == ACL_ST_ARMED [*1] ##0 ARMED_O)
    else $error("continuous mode lost armed state");
  a_armed_holds: assert property (state_r == ACL_ST_ARMED && !cmd_stop && !frame_ok // R13
    |=> state_r == ACL_ST_ARMED)
    else $error("armed state dropped without stop");
  a_stop_idle_now: assert property (state_r == ACL_ST_ARMED && cmd_stop |-> s_disarmed) // R15
    else $error("stop while idle did not disarm at once");
  a_stop_mid_frame: assert property (state_r == ACL_ST_FRAME && cmd_stop && !TRIG_I.frame_done // R15
    |=> state_r == ACL_ST_FRAME && stop_pend_r)
    else $error("stop cut a frame short");
  a_boot_scheme: assert property ($fell(boot_r) |-> scheme_r // R7 R8
    == ($past(STARTUP_I.valid) ? $past(STARTUP_I.scheme) : ACL_LEGACY))
    else $error("startup scheme not restored");

  // further guards on pulses, commands and the read port
  // go is a single pulse: the frame state cannot launch another
  a_go_one_pulse: assert property (FRAME_GO_O |=> !FRAME_GO_O) // R10
    else $error("frame go pulse longer than one cycle");
  // a start from idle arms on the very next edge
  a_start_arms: assert property (state_r == ACL_ST_IDLE && cmd_start |=> state_r == ACL_ST_ARMED && ARMED_O) // R9 R14
    else $error("start command did not arm");
  // a pending stop takes effect at the end of the frame
  a_stop_frame_end: assert property (state_r == ACL_ST_FRAME && stop_pend_r && TRIG_I.frame_done |-> s_disarmed) // R15
    else $error("pending stop did not disarm at frame end");
  // a pending stop can only exist while a frame runs
  a_pend_in_frame: assert property (stop_pend_r |-> state_r == ACL_ST_FRAME) // R15
    else $error("stop pending outside a frame");
  // legacy never opens the gate from the enabling trigger
  a_legacy_no_gate: assert property (scheme_r == ACL_LEGACY && !gate_r |=> !gate_r) // R5
    else $error("legacy scheme opened the acquisition gate");
  // an out-of-range selector leaves the old selection in place
  a_sel_refused: assert property (wr_sel && WR_DATA_I[`ACL_SEL_W-1:0] > `ACL_SEL_LAST |=> sel_r == $past(sel_r)) // R1
    else $error("out-of-range line selector taken");
  // read data stands one cycle only, the port idles at zero
  a_rd_idle_zero: assert property (!RD_I |=> RD_DATA_O == 32'h0000_0000)
    else $error("read data present without a read");
endmodule // acl_top
`default_nettype wire

// *** testbench/acl_top_tb.sv ***
// self-checking bench for the acquisition control and line status block
`timescale 1ns/1ns
`default_nettype none
`include "acl_cfg.svh"
module acl_top_tb;
  import acl_pkg::*;
  //============================================================================
  // stimulus and observation signals
  localparam int FDONE = 0;
  localparam int FSTART = 1;
  localparam int ASTART = 2;
  logic clk;
  logic rst;
  logic [4:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  acl_trig_s trig;
  acl_lines_s lines;
  acl_startup_s boot;
  logic go;
  logic armed;
  logic in_frame;
  int fail_count;
  int checks_done;
  int seed;
  logic [31:0] rd_q[$];
  logic [1:0] fs_q[$];
  logic rd_pend = 1'b0;
  logic fs_pend = 1'b0;

  acl_top #(.ADDR_W(5)) dut
  (
    .CORE_CLK_I(clk),
    .RST_I(rst),
    .ADDR_I(addr),
    .WR_DATA_I(wdata),
    .WR_I(wr),
    .RD_I(rd),
    .RD_DATA_O(rdata),
    .TRIG_I(trig),
    .LINES_I(lines),
    .STARTUP_I(boot),
    .FRAME_GO_O(go),
    .ARMED_O(armed),
    .IN_FRAME_O(in_frame)
  );

  // free-running 100 MHz clock
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  //============================================================================
  // compare, report and close
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  //============================================================================
  // drivers: every request launched just after a rising edge
  task automatic wr_reg(input logic [4:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // read data is only valid the cycle after the strobe, so note it now
  task automatic rd_reg(input logic [4:0] a, input logic [31:0] e);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    rd_q.push_back(e);
    @(posedge clk);
    rd <= 1'b0;
  endtask

  // one-cycle event pulse; e is the expected {go, in_frame} after a frame start
  task automatic pulse(input int k, input logic [1:0] e);
    @(posedge clk);
    trig <= 3'(1 << k);
    if (k == FSTART)
      fs_q.push_back(e);
    @(posedge clk);
    trig <= '0;
  endtask

  task automatic pins(input logic [1:0] e);
    @(negedge clk);
    cmp({30'h0, armed, in_frame}, {30'h0, e});
  endtask

  // startup set stays put while the block samples it after release
  task automatic do_reset(input logic v, input logic s);
    @(posedge clk);
    rst <= 1'b1;
    boot <= {v, s};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
  endtask

  //============================================================================
  // monitor: takes the oldest note whenever a result is due
  always @(posedge clk)
  begin
    rd_pend <= rd;
    fs_pend <= trig.frame_start;
  end

  // falling edge keeps the compare clear of the launching edge
  always @(negedge clk)
  begin
    if (rd_pend)
      cmp(rdata, rd_q.pop_front());
    else if (rdata !== 32'h0)
      cmp(rdata, 32'h0);
    if (fs_pend)
      cmp({30'h0, go, in_frame}, {30'h0, fs_q.pop_front()});
    else if (go !== 1'b0)
      cmp({31'h0, go}, 32'h0);
  end

  // hang guard, generous against the 160 or so cycles needed
  initial
  begin
    repeat (3000) @(posedge clk);
    fail_count++;
    finish_test();
  end

  //============================================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    trig = '0;
    lines = '0;
    boot = '0;
    seed = 33975;
    fail_count = 0;
    checks_done = 0;
    do_reset(1'b0, 1'b0);
    rd_reg(`ACL_OFS_CTRL, 32'h0);
    rd_reg(`ACL_OFS_LINE_SEL, 32'h2);
    rd_reg(`ACL_OFS_CMD, 32'h0);
    rd_reg(5'h1C, 32'h0);
    $display("test reset values done");
    repeat (8)
    begin
      lines <= 6'($random(seed));
      @(posedge clk);
      rd_reg(`ACL_OFS_LINE_ALL, {12'h0, lines.out_lvl, 14'h0, lines.in_lvl});
    end
    for (int s = 0; s < 6; s++)
    begin
      lines <= 6'($random(seed));
      wr_reg(`ACL_OFS_LINE_SEL, 32'(s));
      rd_reg(`ACL_OFS_LINE_STAT, {31'h0, lines[s]});
    end
    wr_reg(`ACL_OFS_LINE_SEL, 32'h6);
    rd_reg(`ACL_OFS_LINE_SEL, 32'h5);
    $display("test line status done");
    // legacy, single frame
    pulse(FSTART, 2'b00);
    wr_reg(`ACL_OFS_CMD, 32'h1);
    pins(2'b10);
    pulse(FSTART, 2'b11);
    pulse(FSTART, 2'b01);
    pulse(FDONE, 2'b00);
    pins(2'b00);
    pulse(FSTART, 2'b00);
    $display("test single frame done");
    // continuous: stays armed until stopped
    wr_reg(`ACL_OFS_CTRL, 32'h1);
    wr_reg(`ACL_OFS_CMD, 32'h1);
    repeat (3)
    begin
      pulse(FSTART, 2'b11);
      pulse(FDONE, 2'b00);
      pins(2'b10);
    end
    wr_reg(`ACL_OFS_CMD, 32'h2);
    pins(2'b00);
    pulse(FSTART, 2'b00);
    // stop in mid-frame waits for the frame to end
    wr_reg(`ACL_OFS_CMD, 32'h1);
    pulse(FSTART, 2'b11);
    wr_reg(`ACL_OFS_CMD, 32'h2);
    pins(2'b11);
    rd_reg(`ACL_OFS_STATUS, 32'hF);
    pulse(FDONE, 2'b00);
    pins(2'b00);
    pulse(FSTART, 2'b00);
    // a fresh start in mid-frame withdraws the pending stop
    wr_reg(`ACL_OFS_CMD, 32'h1);
    pulse(FSTART, 2'b11);
    wr_reg(`ACL_OFS_CMD, 32'h2);
    wr_reg(`ACL_OFS_CMD, 32'h1);
    pulse(FDONE, 2'b00);
    pins(2'b10);
    wr_reg(`ACL_OFS_CMD, 32'h2);
    pins(2'b00);
    $display("test continuous and stop done");
    // standard scheme needs the enabling trigger first
    wr_reg(`ACL_OFS_CTRL, 32'h2);
    rd_reg(`ACL_OFS_CTRL, 32'h2);
    wr_reg(`ACL_OFS_CMD, 32'h1);
    pulse(FSTART, 2'b00);
    pulse(ASTART, 2'b00);
    rd_reg(`ACL_OFS_STATUS, 32'h5);
    pulse(FSTART, 2'b11);
    pulse(FDONE, 2'b00);
    pins(2'b00);
    $display("test standard scheme done");
    // startup set restores the saved scheme
    do_reset(1'b1, 1'b1);
    rd_reg(`ACL_OFS_CTRL, 32'h2);
    pins(2'b00);
    do_reset(1'b0, 1'b1);
    rd_reg(`ACL_OFS_CTRL, 32'h0);
    $display("test startup set done");
    repeat (2) @(posedge clk);
    finish_test();
  end
endmodule // acl_top_tb
`default_nettype wire
